// ---- mlrc_pkg.sv ----
// package with constants and states for the module link and reset control block
// Overview of operation
// - speed select first sets link 0 rate and speed select rest sets links 1 to 3, low is 10 Mbit/s and high is 20 Mbit/s.
// - once the post-reset wait has elapsed the device accepts a boot packet on any link.
// - halt-for-inspection driven with reset stops the processor and keeps its internal state.
// - while halted for inspection the device answers interrogation on any link.
// - the error output is open-collector, pulled low while internal error is raised, floating otherwise.
// - the block runs from one 20 MHz system clock and divides it by four to make the 5 MHz module reference clock.
// - signals with the negation suffix are active low and all others active high.
package mlrc_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned REF_CLK_HZ      = 5000000;
  localparam int unsigned READY_WAIT_MS   = 100;
  localparam int unsigned READY_WAIT_CYC  = (CLK_HZ / 1000) * READY_WAIT_MS;
  localparam int unsigned REF_DIV         = CLK_HZ / REF_CLK_HZ;
  localparam int unsigned LINK_COUNT      = 4;
  localparam logic        RATE_10M        = 1'b0;
  localparam logic        RATE_20M        = 1'b1;
  localparam int unsigned CNT_W           = 22;

  typedef enum logic [1:0] {
    MLRC_RESET = 2'b00,
    MLRC_WAIT  = 2'b01,
    MLRC_READY = 2'b11,
    MLRC_HALT  = 2'b10
  } mlrc_state_e;
endpackage

// ---- mlrc_sync.sv ----
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module mlrc_sync (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_q;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

// ---- mlrc_top.sv ----
// reset sequencing, link speed latch, inspection halt and fault output control
`timescale 1ns/1ps
module mlrc_top #(
  parameter int unsigned READY_WAIT_CYC = mlrc_pkg::READY_WAIT_CYC
) (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RESETN,
  input  wire logic       I_SPEED_SELECT_FIRST,
  input  wire logic       I_SPEED_SELECT_REST,
  input  wire logic       I_INSPECT_REQ,
  input  wire logic       I_INTERNAL_ERROR,
  input  wire logic [3:0] I_SERIAL_LINK_INPUTS,
  output logic      [3:0] O_LINK_RATE,
  output logic      [3:0] O_SERIAL_LINK_INPUTS,
  output logic            O_BOOT_READY,
  output logic            O_HALTED,
  output logic            O_INTERROGATE_READY,
  output logic            O_RUN,
  output logic            O_MODULE_REF_CLOCK,
  output logic            O_FAULT_OUT_N,
  output logic            O_FAULT_OUT_N_OE
);
  logic                        spd_first_s;
  logic                        spd_rest_s;
  logic                        inspect_s;
  logic [3:0]                  link_s;
  logic [3:0]                  link_out_q;
  logic [3:0]                  rate_q;
  logic                        inspect_lat_q;
  logic [mlrc_pkg::CNT_W-1:0]  wait_q;
  logic [1:0]                  div_q;
  logic                        refclk_q;
  logic                        fault_q;
  mlrc_pkg::mlrc_state_e       state_q;
  mlrc_pkg::mlrc_state_e       state_d;

  mlrc_sync u_sync_first (.i_clk(I_CLK_SYS), .i_resetn(1'b1), .i_d(I_SPEED_SELECT_FIRST), .o_q(spd_first_s));
  mlrc_sync u_sync_rest  (.i_clk(I_CLK_SYS), .i_resetn(1'b1), .i_d(I_SPEED_SELECT_REST), .o_q(spd_rest_s));
  mlrc_sync u_sync_insp  (.i_clk(I_CLK_SYS), .i_resetn(1'b1), .i_d(I_INSPECT_REQ), .o_q(inspect_s));

  genvar g;
  generate
    for (g = 0; g < mlrc_pkg::LINK_COUNT; g++) begin : g_link
      mlrc_sync u_sync_link (.i_clk(I_CLK_SYS), .i_resetn(I_RESETN), .i_d(I_SERIAL_LINK_INPUTS[g]),
                             .o_q(link_s[g]));
    end
  endgenerate

  // speeds follow the pins only while in reset, then stay frozen
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      rate_q <= {spd_rest_s, spd_rest_s, spd_rest_s, spd_first_s};
    end
  end

  // inspection request caught while reset is held decides halt vs boot
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      inspect_lat_q <= inspect_s;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      mlrc_pkg::MLRC_RESET: state_d = mlrc_pkg::MLRC_WAIT;
      mlrc_pkg::MLRC_WAIT: begin
        if (wait_q >= mlrc_pkg::CNT_W'(READY_WAIT_CYC - 1)) begin
          state_d = inspect_lat_q ? mlrc_pkg::MLRC_HALT : mlrc_pkg::MLRC_READY;
        end
      end
      mlrc_pkg::MLRC_READY: state_d = mlrc_pkg::MLRC_READY;
      mlrc_pkg::MLRC_HALT:  state_d = mlrc_pkg::MLRC_HALT;
      default:              state_d = mlrc_pkg::MLRC_RESET;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      state_q <= mlrc_pkg::MLRC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // counts the quiet period the host must honour before link traffic
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      wait_q <= '0;
    end else if (state_q == mlrc_pkg::MLRC_WAIT) begin
      wait_q <= wait_q + mlrc_pkg::CNT_W'(1);
    end
  end

  // reference clock divided down from the system clock
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      div_q    <= 2'h0;
      refclk_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'(mlrc_pkg::REF_DIV / 2 - 1) || div_q == 2'(mlrc_pkg::REF_DIV - 1)) begin
        refclk_q <= ~refclk_q;
      end
    end
  end

  // error held in a flop so the open-collector enable is glitch free
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= I_INTERNAL_ERROR;
    end
  end

  // links stay gated until the device can listen; a halted device still answers
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      link_out_q <= 4'h0;
    end else if (O_BOOT_READY || O_HALTED) begin
      link_out_q <= link_s;
    end else begin
      link_out_q <= 4'h0;
    end
  end

  assign O_LINK_RATE          = rate_q;
  assign O_SERIAL_LINK_INPUTS = link_out_q;
  assign O_BOOT_READY         = (state_q == mlrc_pkg::MLRC_READY);
  assign O_HALTED             = (state_q == mlrc_pkg::MLRC_HALT);
  assign O_INTERROGATE_READY  = O_HALTED;
  assign O_RUN                = O_BOOT_READY;
  assign O_MODULE_REF_CLOCK   = refclk_q;
  // only ever drives low, so many modules can share one pull-up
  assign O_FAULT_OUT_N        = 1'b0;
  assign O_FAULT_OUT_N_OE     = fault_q;

  // rate and inspection latching
  AST_RATE_FROZEN: assert property (@(posedge I_CLK_SYS)
    I_RESETN && $past(I_RESETN) |-> $stable(rate_q))
    else $error("link rate changed outside reset");

  // select sync flops have no reset, so only a reset held three edges is judged
  AST_RATE_MAP: assert property (@(posedge I_CLK_SYS)
    !I_RESETN ##1 !I_RESETN ##1 !I_RESETN |=> rate_q[0] == $past(spd_first_s))
    else $error("link 0 rate not from first select");

  AST_RATE_REST: assert property (@(posedge I_CLK_SYS)
    !I_RESETN ##1 !I_RESETN ##1 !I_RESETN |=> rate_q[3:1] == {3{$past(spd_rest_s)}})
    else $error("links 1 to 3 rate not from rest select");

  AST_INSPECT_FROZEN: assert property (@(posedge I_CLK_SYS)
    I_RESETN && $past(I_RESETN) |-> $stable(inspect_lat_q))
    else $error("inspection latch changed outside reset");

  // reset and quiet period
  AST_RESET_QUIET: assert property (@(posedge I_CLK_SYS)
    !I_RESETN |=> !O_BOOT_READY && !O_HALTED && !O_FAULT_OUT_N_OE && O_SERIAL_LINK_INPUTS == 4'h0)
    else $error("outputs active during reset");

  AST_REFCLK_RESET: assert property (@(posedge I_CLK_SYS)
    !I_RESETN |=> !O_MODULE_REF_CLOCK)
    else $error("reference clock running in reset");

  AST_NO_EARLY_READY: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (state_q == mlrc_pkg::MLRC_WAIT) && (wait_q < mlrc_pkg::CNT_W'(READY_WAIT_CYC - 1))
    |=> !O_BOOT_READY && !O_HALTED)
    else $error("ready before wait elapsed");

  AST_WAIT_STEP: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (state_q == mlrc_pkg::MLRC_WAIT) |=> wait_q == $past(wait_q) + mlrc_pkg::CNT_W'(1))
    else $error("quiet period counter skipped");

  AST_WAIT_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    O_BOOT_READY || O_HALTED |=> $stable(wait_q))
    else $error("quiet period counter ran after ready");

  // boot or halt
  AST_READY_AT_END: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (state_q == mlrc_pkg::MLRC_WAIT) && (wait_q == mlrc_pkg::CNT_W'(READY_WAIT_CYC - 1)) && !inspect_lat_q
    |=> O_BOOT_READY)
    else $error("boot ready missing after wait");

  AST_HALT_AT_END: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (state_q == mlrc_pkg::MLRC_WAIT) && (wait_q == mlrc_pkg::CNT_W'(READY_WAIT_CYC - 1)) && inspect_lat_q
    |=> O_HALTED && !O_RUN)
    else $error("inspection halt missing");

  AST_READY_STAYS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    O_BOOT_READY |=> O_BOOT_READY && !O_HALTED)
    else $error("boot ready dropped before reset");

  AST_HALT_STAYS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    O_HALTED |=> O_HALTED && !O_RUN)
    else $error("halt left before reset");

  // links
  AST_HALT_LINKS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    O_HALTED && $past(O_HALTED) |-> O_SERIAL_LINK_INPUTS == $past(link_s) && O_INTERROGATE_READY)
    else $error("halted device not listening on links");

  AST_LINK_PASS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    $past(I_RESETN) && $past(O_BOOT_READY || O_HALTED)
    |-> O_SERIAL_LINK_INPUTS == $past(I_SERIAL_LINK_INPUTS, 3))
    else $error("link input not passed through");

  AST_LINK_GATED: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    $past(!O_BOOT_READY && !O_HALTED) |-> O_SERIAL_LINK_INPUTS == 4'h0)
    else $error("link input passed before ready");

  // fault line and reference clock
  AST_FAULT_OC: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    I_INTERNAL_ERROR |=> O_FAULT_OUT_N_OE && !O_FAULT_OUT_N)
    else $error("fault not pulled low");

  AST_FAULT_FLOAT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    !I_INTERNAL_ERROR |=> !O_FAULT_OUT_N_OE)
    else $error("fault driven without error");

  AST_REFCLK: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    $rose(O_MODULE_REF_CLOCK) |=> O_MODULE_REF_CLOCK ##1 !O_MODULE_REF_CLOCK ##1 !O_MODULE_REF_CLOCK)
    else $error("reference clock not divided by four");
endmodule

// ---- mlrc_far.sv ----
// far side model: shared fault line with one pull-up and other modules
`timescale 1ns/1ps
module mlrc_far (
  input  wire logic       i_fault_n,
  input  wire logic       i_fault_oe,
  input  wire logic [8:0] i_other_oe,
  output logic            o_fault_line
);
  // up to 10 open-collector pullers share one pull-up, so any puller wins
  assign o_fault_line = (i_fault_oe ? i_fault_n : 1'b1) & ~(|i_other_oe);
endmodule

// ---- tb.sv ----
// self-checking bench for link rates, reset sequencing, inspection halt and fault line
`timescale 1ns/1ps
module tb;
  localparam int unsigned WAIT_CYC = 20;
  logic       clk  = 1'b0;
  logic       rstn = 1'b0;
  logic       sa   = 1'b0;
  logic       sb   = 1'b0;
  logic       insp = 1'b0;
  logic       err  = 1'b0;
  logic [3:0] lin  = 4'h0;
  logic [8:0] oth  = 9'h000;
  logic [3:0] rate, lout;
  logic       boot, halt, intr, run, refc, fn, foe, line;
  int         fails = 0;
  int         checks_done = 0;
  always #25 clk = ~clk;
  mlrc_top #(.READY_WAIT_CYC(WAIT_CYC)) dut (.I_CLK_SYS(clk), .I_RESETN(rstn),
    .I_SPEED_SELECT_FIRST(sa), .I_SPEED_SELECT_REST(sb), .I_INSPECT_REQ(insp),
    .I_INTERNAL_ERROR(err), .I_SERIAL_LINK_INPUTS(lin), .O_LINK_RATE(rate),
    .O_SERIAL_LINK_INPUTS(lout), .O_BOOT_READY(boot), .O_HALTED(halt),
    .O_INTERROGATE_READY(intr), .O_RUN(run), .O_MODULE_REF_CLOCK(refc),
    .O_FAULT_OUT_N(fn), .O_FAULT_OUT_N_OE(foe));
  mlrc_far far (.i_fault_n(fn), .i_fault_oe(foe), .i_other_oe(oth), .o_fault_line(line));
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // link traffic is offered during the wait on purpose, to see it refused
  task boot_seq(input logic a, input logic b, input logic i);
    int n;
    n = 0;
    @(posedge clk);
    rstn <= 1'b0;
    sa <= a;
    sb <= b;
    insp <= i;
    lin <= 4'hF;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (WAIT_CYC - 1) @(posedge clk);
    #1 chk("early", 4'h0, {2'b00, boot, halt});
    chk("gate", 4'h0, lout);
    while (boot !== 1'b1 && halt !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 8) begin
      fails++;
      final_report;
    end
    chk("state", {2'b00, ~i, i}, {2'b00, boot, halt});
    chk("alias", {2'b00, ~i, i}, {2'b00, run, intr});
    chk("rate", {b, b, b, a}, rate);
    @(posedge clk);
    sa <= ~a;
    sb <= ~b;
    insp <= ~i;
    lin <= 4'h5;
    repeat (4) @(posedge clk);
    #1 chk("hold", {b, b, b, a}, rate);
    chk("latch", {2'b00, ~i, i}, {2'b00, boot, halt});
    chk("link", 4'h5, lout);
    $display("test boot %b%b%b done", a, b, i);
  endtask
  task fault_test;
    @(posedge clk);
    err <= 1'b1;
    @(posedge clk);
    #1 chk("oe", 4'h1, {3'b000, foe});
    chk("val", 4'h0, {3'b000, fn});
    chk("line", 4'h0, {3'b000, line});
    @(posedge clk);
    err <= 1'b0;
    oth <= 9'h100;
    @(posedge clk);
    #1 chk("float", 4'h0, {3'b000, foe});
    chk("other", 4'h0, {3'b000, line});
    @(posedge clk);
    oth <= 9'h000;
    @(posedge clk);
    #1 chk("idle", 4'h1, {3'b000, line});
    $display("test fault done");
  endtask
  task refclk_test;
    int h;
    int p;
    logic [7:0] s;
    h = 0;
    p = 0;
    s = 8'h00;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 s[k] = refc;
      h += refc;
    end
    for (int k = 0; k < 6; k++) p += (s[k] != s[k+2]);
    chk("refclk", 4'h4, h[3:0]);
    chk("refper", 4'h6, p[3:0]);
    $display("test refclk done");
  endtask
  initial begin
    for (int k = 0; k < 4; k++) boot_seq(k[0], k[1], k[0] ^ k[1]);
    refclk_test;
    fault_test;
    final_report;
  end
endmodule
